// *** core/tsop_params.svh ***
// Constants of the transport stream output port
//
// Function
// RL1: Each decoded transport byte leaves on an eight-bit parallel data port.
// RL2: Port outputs change so the receiver latches them on a chosen byte clock edge.
// RL3: Byte clock keeps toggling through the sixteen slots without payload.
// RL4: Valid is high only for payload, low over the sixteen redundancy slots.
// RL5: Packet start is high with the first byte of each 204 or 160 byte block.
// RL6: Byte strobe rises for each new payload byte, idle over redundancy slots.
// RL7: Uncorrectable block raises the error flag and sets the packet error bit.
// RL8: Full lock asserts only when every sync stage is done and port data valid.
// RL9: Phase lock output asserts once the carrier demodulator is phase locked.
// RL10: Node sync output asserts once the inner decoder reaches node sync.
// RL11: Symbol tick is high one clock per symbol, two cycles for two symbols.
// RL12: Serial bit tap is taken before polarity correction and may be inverted.
// RL13: Active-low reset initialises the block asynchronously to the clock.
// RL14: Reset leaves the captured configuration registers untouched.
// RL15: A buffered copy of the operating clock is driven out.
// RL16: Gain control is a one-bit density stream for external filtering.
// RL17: Serial bit is valid at each rising edge of its bit strobe.
// RL18: Regulated mode runs a steady byte clock; invalid slots carry junk data.
// RL19: Regulated mode with strobe hold keeps the strobe high over valid bytes.
// RL20: Valid, strobe, start and error flags change with their own data byte.
`ifndef TSOP_PARAMS_SVH
`define TSOP_PARAMS_SVH

`define TSOP_PAYLOAD_LONG 8'hBC
`define TSOP_PAYLOAD_SHORT 8'h90
`define TSOP_PARITY_BYTES 8'h10
`define TSOP_POS_RST 8'hFF
`define TSOP_ERR_INDEX 8'h01
`define TSOP_ERR_MASK 8'h80
`define TSOP_FILL_BYTE 8'h00
`define TSOP_SD_RST 9'h000

`endif

// *** core/tsop_pkg.sv ***
// Types of the transport stream output port
package tsop_pkg;

  typedef enum logic {
    TSOP_HALF_LAUNCH,
    TSOP_HALF_SAMPLE
  } tsop_half_type;

  typedef struct packed {
    logic short_block;
    logic edge_rise;
    logic regulate;
    logic strobe_hold;
  } tsop_cfg_type;

  typedef struct packed {
    logic [7:0] hold_data;
    logic hold_payload;
    logic hold_start;
    logic hold_err;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] pos;
    logic blk_err;
    logic live_s1;
    logic live_s2;
    logic phase_lock;
    logic node_sync;
    logic full_lock;
    logic sym_tick;
    logic vb_bit;
    logic vb_pend;
    logic vb_strobe;
    logic [8:0] sd_acc;
  } tsop_core_type;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic pend_full;
    logic [7:0] pend_data;
    logic pend_payload;
    logic pend_start;
    logic pend_err;
    tsop_half_type half;
    logic bclk;
    logic [7:0] out_data;
    logic out_valid;
    logic out_strobe;
    logic out_start;
    logic out_err;
    logic live;
    logic edge_s1;
    logic edge_s2;
    logic reg_s1;
    logic reg_s2;
    logic hold_s1;
    logic hold_s2;
  } tsop_link_type;

endpackage

// *** core/tsop_output_port.sv ***
// Transport stream output port: block framing, byte link, status and test taps
`timescale 1ns/1ps
`include "tsop_params.svh"

module tsop_output_port
  import tsop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic cfg_load,
  input wire logic cfg_short_block,
  input wire logic cfg_edge_rise,
  input wire logic cfg_regulate,
  input wire logic cfg_strobe_hold,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_start,
  input wire logic in_uncorrectable,
  output logic in_ready,
  input wire logic demod_lock_in,
  input wire logic node_sync_in,
  input wire logic byte_sync_in,
  input wire logic rs_sync_in,
  input wire logic symbol_in,
  input wire logic vb_bit_in,
  input wire logic vb_valid_in,
  input wire logic [7:0] gain_level,
  output logic [7:0] ts_data,
  output logic byte_clk,
  output logic ts_valid,
  output logic byte_strobe,
  output logic packet_start,
  output logic uncorrectable,
  output logic full_lock,
  output logic demod_phase_lock,
  output logic inner_decoder_node_sync,
  output logic symbol_tick,
  output logic inner_decoder_serial_bit,
  output logic inner_decoder_bit_strobe,
  output logic gain_control_bit,
  output logic clock_out
);

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  tsop_cfg_type cfg_reg;
  tsop_cfg_type cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_load) begin
      cfg_next.short_block = cfg_short_block;
      cfg_next.edge_rise = cfg_edge_rise;
      cfg_next.regulate = cfg_regulate;
      cfg_next.strobe_hold = cfg_strobe_hold;
    end
  end

  // No reset here so settings survive a chip reset [RL14]
  always_ff @(posedge clock) begin
    cfg_reg <= cfg_next;
  end

  // ------------------------------------------------------------
  // Core domain: block framing and status
  // ------------------------------------------------------------
  tsop_core_type core_reg;
  tsop_core_type core_next;
  tsop_link_type link_reg;
  tsop_link_type link_next;

  logic busy;
  logic accept;
  logic [7:0] plen;
  logic [7:0] blen;
  logic [7:0] idx;
  logic new_blk;
  logic err_now;

  assign busy = core_reg.req_tgl != core_reg.ack_s2;
  assign in_ready = !busy;
  assign accept = in_valid && !busy;
  assign plen = cfg_reg.short_block ? `TSOP_PAYLOAD_SHORT : `TSOP_PAYLOAD_LONG;
  assign blen = plen + `TSOP_PARITY_BYTES;
  // A byte past the block end without a start marker opens a new block
  assign new_blk = in_start || (core_reg.pos >= blen);
  assign idx = new_blk ? 8'h00 : core_reg.pos;
  assign err_now = new_blk ? in_uncorrectable : core_reg.blk_err;

  always_comb begin
    core_next = core_reg;
    core_next.ack_s1 = link_reg.ack_tgl;
    core_next.ack_s2 = core_reg.ack_s1;
    core_next.live_s1 = link_reg.live;
    core_next.live_s2 = core_reg.live_s1;
    if (accept) begin
      core_next.hold_data = in_data;
      if (err_now && idx == `TSOP_ERR_INDEX) begin
        core_next.hold_data = in_data | `TSOP_ERR_MASK; // [RL7]
      end
      core_next.hold_payload = idx < plen; // [RL4]
      core_next.hold_start = new_blk; // [RL5]
      core_next.hold_err = err_now; // [RL7]
      core_next.blk_err = err_now;
      core_next.pos = idx + 8'h01;
      core_next.req_tgl = !core_reg.req_tgl;
    end
    core_next.phase_lock = demod_lock_in; // [RL9]
    core_next.node_sync = node_sync_in; // [RL10]
    core_next.full_lock = demod_lock_in && node_sync_in && byte_sync_in
      && rs_sync_in && core_reg.live_s2; // [RL8]
    core_next.sym_tick = symbol_in; // [RL11]
    // Raw tap, no polarity fix; strobe rises a cycle after the bit [RL12] [RL17]
    core_next.vb_pend = vb_valid_in;
    if (vb_valid_in) begin
      core_next.vb_bit = vb_bit_in;
      core_next.vb_strobe = 1'b0;
    end else if (core_reg.vb_pend) begin
      core_next.vb_strobe = 1'b1;
    end
    // First-order density modulator, carry is the output bit [RL16]
    core_next.sd_acc = {1'b0, core_reg.sd_acc[7:0]} + {1'b0, gain_level};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin // [RL13]
      core_reg <= '0;
      core_reg.pos <= `TSOP_POS_RST;
      core_reg.sd_acc <= `TSOP_SD_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  assign demod_phase_lock = core_reg.phase_lock;
  assign inner_decoder_node_sync = core_reg.node_sync;
  assign full_lock = core_reg.full_lock;
  assign symbol_tick = core_reg.sym_tick;
  assign inner_decoder_serial_bit = core_reg.vb_bit;
  assign inner_decoder_bit_strobe = core_reg.vb_strobe;
  assign gain_control_bit = core_reg.sd_acc[8];
  assign clock_out = clock; // [RL15]

  // ------------------------------------------------------------
  // Link domain: byte clock and port outputs
  // ------------------------------------------------------------
  // The held word is stable for two link edges before the toggle is seen,
  // so it is read across the boundary without its own synchroniser.
  logic capture;
  logic launch;
  tsop_half_type half_nx;

  assign capture = (link_reg.req_s2 != link_reg.req_seen) && !link_reg.pend_full;
  // Launch as the clock leaves its sampling level; tying the phase to the clock
  // level keeps byte_clk toggling across a change of sampling edge. Limitation:
  // the byte period around such a change may be one or three link cycles long.
  assign launch = link_reg.bclk == link_reg.edge_s2; // [RL2]
  assign half_nx = launch ? TSOP_HALF_LAUNCH : TSOP_HALF_SAMPLE;

  always_comb begin
    link_next = link_reg;
    link_next.req_s1 = core_reg.req_tgl;
    link_next.req_s2 = link_reg.req_s1;
    link_next.edge_s1 = cfg_reg.edge_rise;
    link_next.edge_s2 = link_reg.edge_s1;
    link_next.reg_s1 = cfg_reg.regulate;
    link_next.reg_s2 = link_reg.reg_s1;
    link_next.hold_s1 = cfg_reg.strobe_hold;
    link_next.hold_s2 = link_reg.hold_s1;
    link_next.half = half_nx;
    // Free running, also through empty slots [RL3]
    link_next.bclk = !link_reg.bclk; // [RL2]
    if (launch) begin
      if (link_reg.pend_full) begin
        // All qualifiers move with their byte [RL20]
        link_next.out_data = link_reg.pend_data; // [RL1]
        link_next.out_valid = link_reg.pend_payload; // [RL4]
        link_next.out_start = link_reg.pend_start; // [RL5]
        link_next.out_err = link_reg.pend_err; // [RL7]
        link_next.out_strobe = link_reg.reg_s2 && link_reg.hold_s2
          && link_reg.pend_payload; // [RL19]
        link_next.pend_full = 1'b0;
        link_next.live = link_reg.live || link_reg.pend_payload;
      end else begin
        link_next.out_valid = 1'b0;
        link_next.out_start = 1'b0;
        link_next.out_err = 1'b0;
        link_next.out_strobe = 1'b0;
        if (link_reg.reg_s2) begin
          link_next.out_data = `TSOP_FILL_BYTE; // [RL18]
        end
      end
    end else if (link_reg.half == TSOP_HALF_LAUNCH) begin
      // Rises mid period for payload only [RL6]
      link_next.out_strobe = link_reg.out_valid;
    end
    if (capture) begin
      link_next.pend_data = core_reg.hold_data;
      link_next.pend_payload = core_reg.hold_payload;
      link_next.pend_start = core_reg.hold_start;
      link_next.pend_err = core_reg.hold_err;
      link_next.pend_full = 1'b1;
      link_next.req_seen = link_reg.req_s2;
      link_next.ack_tgl = !link_reg.ack_tgl;
    end
  end

  // ------------------------------------------------------------
  // Link reset release
  // ------------------------------------------------------------
  // Reset enters the link domain at once but leaves it through two flops,
  // since its release bears no relation to the link clock
  logic [1:0] link_arm_reg;
  logic [1:0] link_arm_next;
  logic link_rst_n;

  assign link_arm_next = {link_arm_reg[0], 1'h1};

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin // [RL13]
      link_arm_reg <= 2'h0;
    end else begin
      link_arm_reg <= link_arm_next;
    end
  end

  assign link_rst_n = link_arm_reg[1];

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin // [RL13]
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  assign byte_clk = link_reg.bclk;
  assign ts_data = link_reg.out_data;
  assign ts_valid = link_reg.out_valid;
  assign byte_strobe = link_reg.out_strobe;
  assign packet_start = link_reg.out_start;
  assign uncorrectable = link_reg.out_err;

endmodule

// *** tb/tsop_output_port_properties.sv ***
// Pin-level temporal checks of the transport stream output port
`timescale 1ns/1ps
module tsop_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic demod_lock_in,
  input wire logic rs_sync_in,
  input wire logic symbol_in,
  input wire logic vb_bit_in,
  input wire logic vb_valid_in,
  input wire logic byte_clk,
  input wire logic ts_valid,
  input wire logic byte_strobe,
  input wire logic packet_start,
  input wire logic full_lock,
  input wire logic demod_phase_lock,
  input wire logic symbol_tick,
  input wire logic inner_decoder_serial_bit,
  input wire logic inner_decoder_bit_strobe
);
  phase_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> demod_phase_lock == $past(demod_lock_in)) else $error("phase lock");
  tick_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> symbol_tick == $past(symbol_in)) else $error("symbol tick");
  lock_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    !rs_sync_in |-> ##[1:2] !full_lock) else $error("full lock");
  serial_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    vb_valid_in |=> inner_decoder_serial_bit == $past(vb_bit_in)) else $error("serial bit");
  bit_strobe_a: assert property (@(posedge clock) disable iff (!rst_n)
    vb_valid_in |=> !inner_decoder_bit_strobe ##1 inner_decoder_bit_strobe) else $error("strobe");
  // Four edges of grace let a synchronised link reset settle first
  bclk_toggle_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $past(rst_n, 4) |-> byte_clk != $past(byte_clk)) else $error("byte clock");
  start_valid_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    packet_start |-> ts_valid) else $error("start flag");
  strobe_valid_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    byte_strobe |-> ts_valid) else $error("byte strobe");
  start_c: cover property (@(posedge link_clk) $rose(packet_start));
  lock_c: cover property (@(posedge clock) $rose(full_lock));
  bit_c: cover property (@(posedge clock) $rose(inner_decoder_bit_strobe));
endmodule

bind tsop_output_port tsop_chk i_tsop_chk (.*);

// *** tb/tsop_ts_sink.sv ***
// Downstream transport decoder model latching the byte port
`timescale 1ns/1ps
module tsop_ts_sink (
  input wire logic byte_clk,
  input wire logic cfg_edge_rise,
  input wire logic [7:0] ts_data,
  input wire logic ts_valid,
  input wire logic byte_strobe,
  input wire logic packet_start,
  input wire logic uncorrectable,
  output int pay,
  output int stb,
  output logic [7:0] first_byte,
  output logic [7:0] second_byte,
  output logic err_seen
);
  initial begin
    pay = 0;
    stb = 0;
  end
  always @(posedge byte_strobe) stb++;
  // Only the chosen edge latches; the other one launches the next byte
  always @(byte_clk) if (byte_clk === cfg_edge_rise && ts_valid === 1'b1) begin
    if (packet_start) begin
      pay = 0;
      first_byte = ts_data;
      err_seen = uncorrectable;
    end
    pay++;
    if (pay == 2) second_byte = ts_data;
  end
endmodule

// *** tb/transport_stream_output_port_tb.sv ***
// Self-checking bench of the transport stream output port
`timescale 1ns/1ps
module transport_stream_output_port_tb;
  logic clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0, cfg_load = 1'b0, in_valid = 1'b0;
  logic cfg_short_block = 1'b0, cfg_edge_rise = 1'b1, cfg_regulate = 1'b0;
  logic cfg_strobe_hold = 1'b0, in_start = 1'b0, in_uncorrectable = 1'b0, symbol_in = 1'b0;
  logic vb_bit_in = 1'b0, vb_valid_in = 1'b0, demod_lock_in = 1'b0, node_sync_in = 1'b0;
  logic byte_sync_in = 1'b0, rs_sync_in = 1'b0;
  logic [7:0] in_data = 8'h00, gain_level = 8'h00, ts_data, first_byte, second_byte;
  logic in_ready, byte_clk, ts_valid, byte_strobe, packet_start, uncorrectable, full_lock;
  logic demod_phase_lock, inner_decoder_node_sync, symbol_tick, inner_decoder_serial_bit;
  logic inner_decoder_bit_strobe, gain_control_bit, clock_out, err_seen;
  int pay, stb, n_fail = 0, cmp_count = 0, cyc = 0, hold_gap = 0;

  tsop_output_port i_tsop_output_port (.*);
  tsop_ts_sink i_tsop_ts_sink (.*);

  initial forever #2 clock = ~clock;
  initial begin
    #1.3;
    forever #6 link_clk = ~link_clk;
  end

  // Payload time with the strobe low; must stay zero in strobe hold style
  always @(negedge clock) if (ts_valid === 1'b1 && byte_strobe !== 1'b1) hold_gap++;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  // ------
  // Tasks
  // ------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic put(logic [7:0] d, logic s, logic e);
    @(negedge clock);
    {in_data, in_start, in_uncorrectable, in_valid} = {d, s, e, 1'b1};
    while (in_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    in_valid = 1'b0;
  endtask

  // One whole block: payload then sixteen redundancy bytes
  task automatic blk(logic [3:0] cfg, logic e, logic ld);
    int plen, s0, h0;
    if (ld) begin
      @(negedge clock);
      {cfg_short_block, cfg_edge_rise, cfg_regulate, cfg_strobe_hold, cfg_load} = {cfg, 1'b1};
      @(negedge clock);
      cfg_load = 1'b0;
      repeat (8) @(negedge clock);
    end
    plen = cfg_short_block ? 144 : 188;
    s0 = stb;
    h0 = hold_gap;
    for (int i = 0; i < plen + 16; i++) put(8'h47 + i[7:0], i == 0, e);
    repeat (30) @(negedge clock);
    chk("payload", 16'(pay), 16'(plen));
    chk("first", first_byte, 8'h47);
    chk("error_byte", second_byte, {e, 7'h48});
    chk("error_flag", err_seen, e);
    if (!cfg_strobe_hold) chk("strobes", 16'(stb - s0), 16'(plen));
    else chk("strobe_hold", 16'(hold_gap - h0), 16'h0000);
    chk("idle_data", ts_data, cfg_regulate ? 8'h00 : 8'(8'h47 + plen + 15));
  endtask

  initial begin
    int g;
    g = 0;
    // The settings have no reset, so they are loaded while reset is held
    cfg_load = 1'b1;
    repeat (12) @(negedge clock);
    cfg_load = 1'b0;
    rst_n = 1'b1;
    {demod_lock_in, node_sync_in, byte_sync_in, rs_sync_in} = 4'hF;
    gain_level = 8'h40;
    repeat (4) @(negedge clock);
    chk("early_lock", full_lock, 1'b0);
    chk("node_sync", inner_decoder_node_sync, 1'b1);
    #1 chk("clock_copy", clock_out, 1'b0);
    #2 chk("clock_copy", clock_out, 1'b1);
    for (int i = 0; i < 256; i++) begin
      @(negedge clock);
      g += gain_control_bit;
    end
    chk("gain_density", 16'(g), 16'h0040);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      {symbol_in, vb_valid_in, vb_bit_in} = {2'b11, i[0]};
      @(negedge clock);
      {symbol_in, vb_valid_in} = 2'b00;
      @(negedge clock);
      chk("serial", {inner_decoder_bit_strobe, inner_decoder_serial_bit}, {1'b1, i[0]});
    end
    blk(4'b0100, 1'b0, 1'b1);
    chk("lock", full_lock, 1'b1);
    blk(4'b0100, 1'b1, 1'b0);
    blk(4'b0011, 1'b0, 1'b1);
    blk(4'b1100, 1'b0, 1'b1);
    rst_n = 1'b0;
    repeat (12) @(negedge clock);
    chk("reset_lock", full_lock, 1'b0);
    rst_n = 1'b1;
    blk(4'b1100, 1'b0, 1'b0);
    rs_sync_in = 1'b0;
    repeat (3) @(negedge clock);
    chk("lock_drop", full_lock, 1'b0);
    complete_run();
  end
endmodule
